/* File: include/eip_pkg.sv */
// Purpose: shared constants and types of the id page lock/protect block
// Assumes: spi mode 0/3 link, 125 MHz reference clock
// Notes:   opcode bit 3 is a don't care and is never compared
package eip_pkg;
    // opcode layout 1000 x01y: high nibble and low three bits
    localparam logic [3:0]  OP_HI          = 4'h8;
    localparam logic [2:0]  OP_LO_WRITE    = 3'h2;
    localparam logic [2:0]  OP_LO_READ     = 3'h3;
    // bit positions within a frame, counted from the first latched bit
    localparam logic [5:0]  CNT_OP_LAST    = 6'h07;
    localparam logic [5:0]  CNT_A10        = 6'h0d;
    localparam logic [5:0]  CNT_HDR_LAST   = 6'h17;
    localparam logic [5:0]  CNT_HDR_LEN    = 6'h18;
    localparam int          LOCK_DATA_BIT  = 1;
    localparam int          PAGE_BYTES     = 64;
    localparam int          PAGE_AW        = 6;
    localparam int          ARR_AW         = 14;
    // block protect codes {hi, lo}
    localparam logic [1:0]  BP_QUARTER     = 2'h1;
    localparam logic [1:0]  BP_HALF        = 2'h2;
    localparam logic [1:0]  BP_ALL         = 2'h3;
    // reset values
    localparam logic        WEL_RST        = 1'h0;
    localparam logic        LOCK_RST       = 1'h0;
    localparam logic [7:0]  SHIFT_RST      = 8'h00;
    // self-timed write cycle
    localparam longint      T_WR_NS        = 5000000;
    localparam longint      REF_PERIOD_NS  = 8;
    localparam int          WR_CYCLES_DEF  = int'(T_WR_NS / REF_PERIOD_NS);
    localparam int          WR_TMR_W       = 20;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COPY = 3'b010,
        ST_WAIT = 3'b100
    } eip_wr_st_t;
endpackage : eip_pkg

/* File: core/eip_sync2.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: input is a level, stable for at least two destination edges
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module eip_sync2 (
    input  wire logic i_clk,     // destination clock
    input  wire logic i_rst_n,   // async reset, active low
    input  wire logic i_d,       // asynchronous level
    output logic      o_q        // synchronised level
);
    logic meta_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= 1'h0;
            o_q    <= 1'h0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule : eip_sync2

/* File: core/eip_page_mem.sv */
// Purpose: 64 x 8 page store, one write port, registered read port
// Assumes: single clock
// Notes:   read data appear one clock after the address
`timescale 1ns/1ps
module eip_page_mem
    import eip_pkg::*;
(
    input  wire logic               i_clk,    // clock
    input  wire logic               i_we,     // write strobe
    input  wire logic [PAGE_AW-1:0] i_waddr,  // write byte index
    input  wire logic [7:0]         i_wdata,  // write byte
    input  wire logic [PAGE_AW-1:0] i_raddr,  // read byte index
    output logic      [7:0]         o_rdata   // registered read byte
);
    logic [7:0] mem_r [PAGE_BYTES];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_r[i_raddr];
    end
endmodule : eip_page_mem

/* File: core/eip_id_lock.sv */
// Purpose: id page write, lock status read, lock command, write-protect matrix
// Assumes: host keeps sck still while chip select is high; link regs are then quiet
// Notes:   lock bit is volatile here, cleared only by i_rst_n (power-on)
`timescale 1ns/1ps
module eip_id_lock
    import eip_pkg::*;
#(
    parameter int WR_CYCLES = WR_CYCLES_DEF                  // write cycle length in clocks
) (
    input  wire logic               i_ref_clk,               // core clock, 125 MHz
    input  wire logic               i_rst_n,                 // power-on reset, active low
    input  wire logic               i_sck,                   // spi serial clock
    input  wire logic               i_cs_n,                  // chip select, active low
    input  wire logic               i_si,                    // serial data in
    output logic                    o_so,                    // serial data out
    output logic                    o_so_oe,                 // serial out enable
    input  wire logic               i_set_write_enable_cmd,  // latch set pulse
    input  wire logic               i_block_protect_hi,      // block protect bit 1
    input  wire logic               i_block_protect_lo,      // block protect bit 0
    input  wire logic               i_status_protect_enable, // hardware protect enable
    input  wire logic               i_wp_n,                  // protect pin, async
    input  wire logic [15:0]        i_arr_addr,              // array address to check
    output logic                    o_arr_writable,          // array address writable
    output logic                    o_status_writable,       // protect fields writable
    output logic [ARR_AW-1:0]       o_arr_index,             // significant array address
    input  wire logic [PAGE_AW-1:0] i_page_rd_addr,          // page read byte index
    output logic      [7:0]         o_page_rd_data,          // page read byte
    output logic                    o_write_enable_latch,    // latch state
    output logic                    o_busy,                  // write cycle running
    output logic                    o_id_locked              // page lock state
);
    // ---------------- link domain (i_sck) ----------------
    logic               lk_clr;
    logic               lk_started_r, lk_started_nxt;
    logic               lk_rd_r, lk_rd_nxt;
    logic [5:0]         lk_cnt_r, lk_cnt_nxt;
    logic [2:0]         lk_bpos_r, lk_bpos_nxt;
    logic [7:0]         lk_sh_r, lk_sh_nxt;
    logic [7:0]         lk_op_r, lk_op_nxt;
    logic               lk_a10_r, lk_a10_nxt;
    logic [PAGE_AW-1:0] lk_addr_r, lk_addr_nxt;
    logic [PAGE_AW-1:0] lk_waddr_r, lk_waddr_nxt;
    logic [7:0]         lk_byte_r, lk_byte_nxt;
    logic               lk_got_r, lk_got_nxt;
    logic               lk_tog_r, lk_tog_nxt;
    logic               lk_lock_s;
    logic [2:0]         lk_oidx_r;
    logic [5:0]         cnt_cur;
    logic               op_wr, op_rd;

    assign lk_clr = i_cs_n | ~i_rst_n;
    // opcode register is settled before its first use at bit 23
    assign op_wr  = (lk_op_r[7:4] == OP_HI) && (lk_op_r[2:0] == OP_LO_WRITE);
    assign op_rd  = (lk_op_r[7:4] == OP_HI) && (lk_op_r[2:0] == OP_LO_READ);

    always_comb begin
        cnt_cur        = lk_started_r ? lk_cnt_r : 6'h00;
        lk_started_nxt = 1'h1;
        lk_sh_nxt      = {lk_sh_r[6:0], i_si};
        lk_op_nxt      = lk_op_r;
        lk_a10_nxt     = lk_a10_r;
        lk_addr_nxt    = lk_addr_r;
        lk_waddr_nxt   = lk_waddr_r;
        lk_byte_nxt    = lk_byte_r;
        lk_got_nxt     = lk_started_r & lk_got_r;
        lk_tog_nxt     = lk_tog_r;
        lk_bpos_nxt    = 3'h0;
        lk_rd_nxt      = lk_rd_r;
        lk_cnt_nxt     = (cnt_cur == CNT_HDR_LEN) ? cnt_cur : cnt_cur + 6'h01;
        if (cnt_cur == CNT_OP_LAST) begin
            lk_op_nxt = lk_sh_nxt;
        end
        if (cnt_cur == CNT_A10) begin
            lk_a10_nxt = i_si;
        end
        if (cnt_cur == CNT_HDR_LAST) begin
            lk_addr_nxt = lk_sh_nxt[PAGE_AW-1:0];
            // status query: read class with A10 set, drive from next falling edge
            lk_rd_nxt   = op_rd & lk_a10_r;
        end
        if (cnt_cur == CNT_HDR_LEN) begin
            lk_bpos_nxt = lk_bpos_r + 3'h1;
            if (lk_bpos_r == 3'h7) begin
                lk_byte_nxt  = lk_sh_nxt;
                lk_got_nxt   = 1'h1;
                lk_waddr_nxt = lk_addr_r;
                lk_addr_nxt  = lk_addr_r + 6'h01;
                // every page-write byte is handed over; core filters at commit
                lk_tog_nxt   = lk_tog_r ^ (op_wr & ~lk_a10_r);
            end
        end
    end

    // state that the core samples after deselect is not cleared by chip select
    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_cnt_r   <= 6'h00;
            lk_bpos_r  <= 3'h0;
            lk_sh_r    <= SHIFT_RST;
            lk_op_r    <= SHIFT_RST;
            lk_a10_r   <= 1'h0;
            lk_addr_r  <= '0;
            lk_waddr_r <= '0;
            lk_byte_r  <= SHIFT_RST;
            lk_got_r   <= 1'h0;
            lk_tog_r   <= 1'h0;
        end else begin
            lk_cnt_r   <= lk_cnt_nxt;
            lk_bpos_r  <= lk_bpos_nxt;
            lk_sh_r    <= lk_sh_nxt;
            lk_op_r    <= lk_op_nxt;
            lk_a10_r   <= lk_a10_nxt;
            lk_addr_r  <= lk_addr_nxt;
            lk_waddr_r <= lk_waddr_nxt;
            lk_byte_r  <= lk_byte_nxt;
            lk_got_r   <= lk_got_nxt;
            lk_tog_r   <= lk_tog_nxt;
        end
    end

    // frame flags end with the frame itself
    always_ff @(posedge i_sck or posedge lk_clr) begin
        if (lk_clr) begin
            lk_started_r <= 1'h0;
            lk_rd_r      <= 1'h0;
        end else begin
            lk_started_r <= lk_started_nxt;
            lk_rd_r      <= lk_rd_nxt;
        end
    end

    // status byte 0000_000L repeated while selected
    always_ff @(negedge i_sck or posedge lk_clr) begin
        if (lk_clr) begin
            o_so      <= 1'h0;
            lk_oidx_r <= 3'h7;
        end else if (lk_rd_r) begin
            o_so      <= (lk_oidx_r == 3'h0) & lk_lock_s;
            lk_oidx_r <= lk_oidx_r - 3'h1;
        end
    end

    assign o_so_oe = lk_rd_r;

    eip_sync2 u_lock_to_link (
        .i_clk   (i_sck),
        .i_rst_n (i_rst_n),
        .i_d     (o_id_locked),
        .o_q     (lk_lock_s)
    );

    // ---------------- core domain (i_ref_clk) ----------------
    eip_wr_st_t           st_r, st_nxt;
    logic                 cs_s, cs_q_r, tg_s, tg_q_r, wp_s;
    logic                 cs_rise, cs_fall, byte_ev;
    logic                 wel_r, wel_nxt, lock_r, lock_nxt, kind_lock_r, kind_lock_nxt;
    logic [WR_TMR_W-1:0]  tmr_r, tmr_nxt;
    logic [PAGE_AW:0]     cp_idx_r, cp_idx_nxt;
    logic [PAGE_AW-1:0]   cp_wa_r, cp_wa_nxt;
    logic                 cp_vld_r, cp_vld_nxt;
    logic [PAGE_BYTES-1:0] dirty_r, dirty_nxt;
    logic                 boundary, hw_prot, in_block, lock_ok, idw_ok;
    logic                 arr_wr_nxt, st_wr_nxt;
    logic [7:0]           stage_rd;
    logic [PAGE_AW-1:0]   page_raddr;
    localparam logic [WR_TMR_W-1:0] WR_LAST = WR_TMR_W'(WR_CYCLES - 1);

    // select synced active high: sync reset level is then the idle level, no false edge
    eip_sync2 u_cs_sync  (.i_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_d(~i_cs_n),  .o_q(cs_s));
    eip_sync2 u_tog_sync (.i_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_d(lk_tog_r), .o_q(tg_s));
    eip_sync2 u_wp_sync  (.i_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_d(i_wp_n),   .o_q(wp_s));

    assign cs_rise  = ~cs_s & cs_q_r;
    assign cs_fall  = cs_s & ~cs_q_r;
    assign byte_ev  = tg_s ^ tg_q_r;
    // deselect landed right after a whole data byte
    assign boundary = lk_got_r && (lk_cnt_r == CNT_HDR_LEN) && (lk_bpos_r == 3'h0);
    assign lock_ok  = (lk_op_r[7:4] == OP_HI) && (lk_op_r[2:0] == OP_LO_WRITE) && lk_a10_r
                      && lk_byte_r[LOCK_DATA_BIT] && boundary
                      && wel_r && ({i_block_protect_hi, i_block_protect_lo} != BP_ALL)
                      && (st_r == ST_IDLE) && !lock_r;
    assign idw_ok   = (lk_op_r[7:4] == OP_HI) && (lk_op_r[2:0] == OP_LO_WRITE) && !lk_a10_r
                      && boundary && wel_r && !lock_r && (st_r == ST_IDLE);

    always_comb begin
        st_nxt        = st_r;
        wel_nxt       = wel_r | i_set_write_enable_cmd;
        lock_nxt      = lock_r;
        kind_lock_nxt = kind_lock_r;
        tmr_nxt       = tmr_r + 1'b1;
        cp_idx_nxt    = cp_idx_r;
        cp_wa_nxt     = cp_idx_r[PAGE_AW-1:0];
        cp_vld_nxt    = 1'h0;
        dirty_nxt     = dirty_r;
        // a frame opened during a write must not wipe the copy in flight
        if (cs_fall && st_r == ST_IDLE) begin
            dirty_nxt = '0;
        end
        unique case (st_r)
            ST_IDLE: begin
                tmr_nxt = '0;
                if (cs_rise && (lock_ok || idw_ok)) begin
                    kind_lock_nxt = lock_ok;
                    cp_idx_nxt    = '0;
                    st_nxt        = lock_ok ? ST_WAIT : ST_COPY;
                end
            end
            ST_COPY: begin
                // stage read is registered, so page write trails by a clock
                cp_vld_nxt = ~cp_idx_r[PAGE_AW];
                cp_idx_nxt = cp_idx_r + 1'b1;
                if (cp_idx_r[PAGE_AW]) begin
                    dirty_nxt = '0;
                    st_nxt    = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tmr_r >= WR_LAST) begin
                    st_nxt   = ST_IDLE;
                    wel_nxt  = 1'h0;
                    lock_nxt = lock_r | kind_lock_r;
                end
            end
        endcase
        // a byte arriving with a clear still wins
        if (byte_ev && st_r == ST_IDLE) begin
            dirty_nxt[lk_waddr_r] = 1'h1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r        <= ST_IDLE;
            cs_q_r      <= 1'h0;
            tg_q_r      <= 1'h0;
            wel_r       <= WEL_RST;
            lock_r      <= LOCK_RST;
            kind_lock_r <= 1'h0;
            tmr_r       <= '0;
            cp_idx_r    <= '0;
            cp_wa_r     <= '0;
            cp_vld_r    <= 1'h0;
            dirty_r     <= '0;
        end else begin
            st_r        <= st_nxt;
            cs_q_r      <= cs_s;
            tg_q_r      <= tg_s;
            wel_r       <= wel_nxt;
            lock_r      <= lock_nxt;
            kind_lock_r <= kind_lock_nxt;
            tmr_r       <= tmr_nxt;
            cp_idx_r    <= cp_idx_nxt;
            cp_wa_r     <= cp_wa_nxt;
            cp_vld_r    <= cp_vld_nxt;
            dirty_r     <= dirty_nxt;
        end
    end

    eip_page_mem u_stage (
        .i_clk   (i_ref_clk),
        .i_we    (byte_ev && st_r == ST_IDLE),
        .i_waddr (lk_waddr_r),
        .i_wdata (lk_byte_r),
        .i_raddr (cp_idx_r[PAGE_AW-1:0]),
        .o_rdata (stage_rd)
    );

    assign page_raddr = (st_r == ST_COPY) ? cp_idx_r[PAGE_AW-1:0] : i_page_rd_addr;

    eip_page_mem u_page (
        .i_clk   (i_ref_clk),
        .i_we    (cp_vld_r & dirty_r[cp_wa_r]),
        .i_waddr (cp_wa_r),
        .i_wdata (stage_rd),
        .i_raddr (page_raddr),
        .o_rdata (o_page_rd_data)
    );

    // ---------------- protection matrix ----------------
    assign hw_prot = i_status_protect_enable & ~wp_s;
    always_comb begin
        unique case ({i_block_protect_hi, i_block_protect_lo})
            BP_QUARTER: in_block = (i_arr_addr[13:12] == 2'h3);
            BP_HALF:    in_block = i_arr_addr[13];
            BP_ALL:     in_block = 1'h1;
            default:    in_block = 1'h0;
        endcase
        arr_wr_nxt = wel_r & ~in_block;
        st_wr_nxt  = wel_r & ~hw_prot;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arr_writable    <= 1'h0;
            o_status_writable <= 1'h0;
            o_arr_index       <= '0;
        end else begin
            o_arr_writable    <= arr_wr_nxt;
            o_status_writable <= st_wr_nxt;
            o_arr_index       <= i_arr_addr[ARR_AW-1:0];
        end
    end

    assign o_write_enable_latch = wel_r;
    assign o_busy               = (st_r != ST_IDLE);
    assign o_id_locked          = lock_r;
endmodule : eip_id_lock

/* File: sim/eip_id_lock_monitor.sv */
// Purpose: concurrent checks on the id page lock block ports
// Assumes: WR_CYCLES equals the value given to the design instance
// Notes:   write cycle length judged by a small busy counter
`timescale 1ns/1ps
module eip_id_lock_monitor
    import eip_pkg::*;
#(
    parameter int WR_CYCLES = 200                           // write cycle length
) (
    input wire logic              i_ref_clk,                // core clock
    input wire logic              i_rst_n,                  // reset, active low
    input wire logic              i_cs_n,                   // chip select
    input wire logic              o_so_oe,                  // serial out enable
    input wire logic              i_set_write_enable_cmd,   // latch set pulse
    input wire logic              i_block_protect_hi,       // block protect bit 1
    input wire logic              i_block_protect_lo,       // block protect bit 0
    input wire logic              i_status_protect_enable,  // hw protect enable
    input wire logic              i_wp_n,                   // protect pin
    input wire logic [15:0]       i_arr_addr,               // array address
    input wire logic              o_arr_writable,           // array writable
    input wire logic              o_status_writable,        // status writable
    input wire logic [ARR_AW-1:0] o_arr_index,              // array index
    input wire logic              o_write_enable_latch,     // latch state
    input wire logic              o_busy,                   // write cycle running
    input wire logic              o_id_locked               // lock state
);
    int   busy_cnt_r;
    int   busy_cnt_nxt;
    logic in_blk;
    always_comb begin
        busy_cnt_nxt = o_busy ? busy_cnt_r + 1 : 0;
        in_blk = ({i_block_protect_hi, i_block_protect_lo} == BP_ALL)
            || ({i_block_protect_hi, i_block_protect_lo} == BP_HALF && i_arr_addr[13])
            || ({i_block_protect_hi, i_block_protect_lo} == BP_QUARTER
                && i_arr_addr[13:12] == 2'h3);
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end
    a_oe_needs_sel: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_so_oe |-> !i_cs_n) else $error("so enabled while deselected");
    a_latch_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_set_write_enable_cmd && !o_busy |=> o_write_enable_latch)
        else $error("latch not set by pulse");
    a_done_clears_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(o_busy) |-> !o_write_enable_latch) else $error("latch kept after write");
    a_lock_sticks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_id_locked |=> o_id_locked) else $error("lock bit cleared");
    a_lock_after_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(o_id_locked) |-> $past(o_busy)) else $error("lock set without write cycle");
    a_cycle_length: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(o_busy) |-> busy_cnt_r >= WR_CYCLES - 8 && busy_cnt_r <= WR_CYCLES + 8)
        else $error("write cycle length off");
    a_cycle_bounded: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        busy_cnt_r <= WR_CYCLES + 8) else $error("write cycle overran");
    a_status_no_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !$past(o_write_enable_latch) |-> !o_status_writable)
        else $error("status writable without latch");
    a_status_hw_prot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_status_protect_enable && !i_wp_n) [*4] |-> !o_status_writable)
        else $error("status writable under hw protect");
    a_block_ro: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $past(in_blk) |-> !o_arr_writable) else $error("protected block writable");
    a_outside_rw: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $past(o_write_enable_latch && !in_blk) |-> o_arr_writable)
        else $error("unprotected array refused");
    a_index_bits: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_arr_index == $past(i_arr_addr[13:0])) else $error("array index wrong");
endmodule : eip_id_lock_monitor
bind eip_id_lock eip_id_lock_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .o_so_oe(o_so_oe),
    .i_set_write_enable_cmd(i_set_write_enable_cmd), .i_block_protect_hi(i_block_protect_hi),
    .i_block_protect_lo(i_block_protect_lo), .i_wp_n(i_wp_n),
    .i_status_protect_enable(i_status_protect_enable), .i_arr_addr(i_arr_addr),
    .o_arr_writable(o_arr_writable), .o_status_writable(o_status_writable),
    .o_arr_index(o_arr_index), .o_write_enable_latch(o_write_enable_latch),
    .o_busy(o_busy), .o_id_locked(o_id_locked)
);

/* File: sim/eip_spi_host.sv */
// Purpose: behavioural spi host sending frames to the id page block
// Assumes: mode 0, sck period 15 ns, sck idles low between frames
// Notes:   so counts only while enabled, otherwise taken as unknown
`timescale 1ns/1ps
module eip_spi_host (
    output logic      o_sck,    // serial clock
    output logic      o_cs_n,   // chip select, active low
    output logic      o_si,     // serial data to device
    input  wire logic i_so,     // serial data from device
    input  wire logic i_so_oe   // device output enable
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // data bytes run d0, d0+1, ...; nx stray bits break the byte boundary
    task automatic frame(input logic [7:0] op, input logic [15:0] adr, input int nd,
                         input logic [7:0] d0, input int nx,
                         output logic [7:0] rx_first, output logic [7:0] rx_last);
        logic [7:0] b;
        logic [7:0] sh;
        int         k;
        int         i;
        sh = 8'h00;
        rx_first = 8'h00;
        rx_last = 8'h00;
        o_cs_n = 1'b0;
        #7.5;
        for (k = -3; k < nd + (nx > 0 ? 1 : 0); k++) begin
            b = (k == -3) ? op : (k == -2) ? adr[15:8] : (k == -1) ? adr[7:0] : d0 + 8'(k);
            for (i = 7; i >= 0 && (k < nd || 7 - i < nx); i--) begin
                o_si = b[i];
                #7.5;
                sh = {sh[6:0], i_so_oe ? i_so : 1'bx};
                o_sck = 1'b1;
                #7.5;
                o_sck = 1'b0;
            end
            if (k == 0) rx_first = sh;
            if (k >= 0) rx_last = sh;
        end
        #3;
        o_cs_n = 1'b1;
        o_si = ~o_si;
        #48;
    endtask : frame
endmodule : eip_spi_host

/* File: sim/eip_id_lock_tb.sv */
// Purpose: self-checking bench for the id page lock block
// Assumes: short write cycle parameter, host model on the link
// Notes:   inputs change on the falling reference edge
`timescale 1ns/1ps
module eip_id_lock_tb;
    import eip_pkg::*;
    localparam int WRC = 200;
    logic i_ref_clk, i_rst_n, sck, cs_n, si, so, so_oe, wen, bp_hi, bp_lo, spe, wp_n;
    logic [15:0] arr, a;
    logic [13:0] idx;
    logic [5:0] pg_addr;
    logic [7:0] pg_data, rf, rl, d0;
    logic [7:0] page [64];
    logic aw, sw, write_enable_latch, busy, locked;
    logic [31:0] seed = 32'h098a;
    int err_count = 0, n_tests = 0, cycles = 0, k;

    eip_spi_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
    eip_id_lock #(.WR_CYCLES(WRC)) dut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_set_write_enable_cmd(wen), .i_block_protect_hi(bp_hi),
        .i_block_protect_lo(bp_lo), .i_status_protect_enable(spe), .i_wp_n(wp_n),
        .i_arr_addr(arr), .o_arr_writable(aw), .o_status_writable(sw), .o_arr_index(idx),
        .i_page_rd_addr(pg_addr), .o_page_rd_data(pg_data), .o_write_enable_latch(write_enable_latch),
        .o_busy(busy), .o_id_locked(locked));

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            $display("unexpected t=%0t timeout after %h cycles", $time, cycles);
            stop_test();
        end
    end

    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // expected {array writable, status writable}; m is {bp hi, bp lo, enable, pin}
    function automatic logic [1:0] exp_wr(input logic [15:0] ad, input logic [3:0] m,
                                          input logic we);
        logic blk;
        blk = (m[3:2] == BP_ALL) || (m[3:2] == BP_HALF && ad[13])
            || (m[3:2] == BP_QUARTER && ad[13:12] == 2'h3);
        return {we && !blk, we && !(m[1] && !m[0])};
    endfunction : exp_wr
    function automatic logic [7:0] opc(input logic [2:0] lo);
        seed = lfsr(seed);
        return {OP_HI, seed[0], lo};
    endfunction : opc
    task set_wel;
        @(negedge i_ref_clk) wen = 1'b1;
        @(negedge i_ref_clk) wen = 1'b0;
        chk(write_enable_latch, 1'b1);
    endtask : set_wel
    task wait_busy(input logic lvl);
        for (int n = 0; n < 400 && busy !== lvl; n++) @(negedge i_ref_clk);
        chk(busy, lvl);
    endtask : wait_busy
    task expect_idle(input logic lk);
        repeat (10) @(negedge i_ref_clk);
        chk(busy, 1'b0);
        chk(locked, lk);
    endtask : expect_idle
    task chk_page(input int n);
        for (int j = 0; j < n; j++) begin
            @(negedge i_ref_clk) pg_addr = 6'(j);
            @(negedge i_ref_clk) chk(pg_data, page[j]);
        end
    endtask : chk_page

    initial begin
        {i_rst_n, wen, bp_hi, bp_lo, spe, wp_n, arr, pg_addr} = {6'b000001, 22'h0};
        repeat (3) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        seed = lfsr(seed);
        u_host.frame(opc(OP_LO_READ), seed[15:0] | 16'h0400, 3, 8'h00, 0, rf, rl);
        chk(rf, 8'h00);
        chk(rl, 8'h00);
        chk(so_oe, 1'b0);
        u_host.frame(opc(OP_LO_WRITE), 16'h0400, 1, 8'h02, 0, rf, rl);
        expect_idle(1'b0);
        for (k = 0; k < 32; k++) begin
            if (k == 16) set_wel();
            seed = lfsr(seed);
            @(negedge i_ref_clk) {bp_hi, bp_lo, spe, wp_n, arr} = {4'(k), seed[15:0]};
            repeat (4) @(negedge i_ref_clk);
            chk(16'({aw, sw}), 16'(exp_wr(arr, 4'(k), k >= 16)));
            chk(16'(idx), 16'(arr[13:0]));
        end
        // latch held: refused for bit1 clear, stray bits, full block protect
        for (k = 0; k < 3; k++) begin
            @(negedge i_ref_clk) {bp_hi, bp_lo, spe, wp_n} = (k == 2) ? 4'hc : 4'h1;
            u_host.frame(opc(OP_LO_WRITE), 16'hfc00, 1, (k == 0) ? 8'hfd : 8'h02,
                         (k == 1) ? 3 : 0, rf, rl);
            expect_idle(1'b0);
        end
        @(negedge i_ref_clk) {bp_hi, bp_lo} = 2'h0;
        seed = lfsr(seed);
        a = seed[15:0] & 16'hfbff;
        d0 = seed[23:16];
        for (k = 0; k < 66; k++) page[(a[5:0] + k) % 64] = d0 + 8'(k);
        u_host.frame(opc(OP_LO_WRITE), a, 66, d0, 0, rf, rl);
        wait_busy(1'b1);
        u_host.frame(opc(OP_LO_WRITE), 16'h0400, 1, 8'h02, 0, rf, rl);
        wait_busy(1'b0);
        chk(write_enable_latch, 1'b0);
        chk(locked, 1'b0);
        chk_page(64);
        set_wel();
        u_host.frame(opc(OP_LO_WRITE), 16'h0400 | a, 1, seed[7:0] | 8'h02, 0, rf, rl);
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk(locked, 1'b1);
        chk(write_enable_latch, 1'b0);
        u_host.frame(opc(OP_LO_READ), 16'h0400, 3, 8'h5a, 0, rf, rl);
        chk(rf, 8'h01);
        chk(rl, 8'h01);
        chk(so_oe, 1'b0);
        set_wel();
        u_host.frame(opc(OP_LO_WRITE), 16'h0000, 1, ~page[0], 0, rf, rl);
        expect_idle(1'b1);
        chk_page(1);
        u_host.frame(opc(OP_LO_WRITE), 16'h0400, 1, 8'h02, 0, rf, rl);
        expect_idle(1'b1);
        stop_test();
    end
endmodule : eip_id_lock_tb
